// File: irq_mgr_pkg.sv
// Constants and carrier types for the vectored interrupt manager
//
// Function
// - Ninety-six request channels, numbered from zero
// - Per-channel priority and enable; disabled never forwarded
// - Hardware dispatch of highest-priority vector to core
// - Software dispatch: pending index or vector register
// - Vector table stores parity, checked on each dispatch read of the winner's entry; the phantom fallback is not checked
// - Entry zero phantom; channel n uses n+1, channel 95 the phantom
// - Channel 0 error-unit high request; channel 1 reserved
// - Tick compares on 2-5, overflows on 6-7
// - Channel 20 error low; 21 software interrupt
// - High-end timer 10/24; transfer unit 11/25
// - Converter requests on channels 14, 15, 28, 31
// - CAN two on 35/42; serial three 37/38
package irq_mgr_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned CHAN_COUNT  = 96;   // Request channels
  localparam int unsigned CHAN_W      = 7;    // Channel number width
  localparam int unsigned INDEX_W     = 8;    // Index output width
  localparam int unsigned VEC_W       = 32;   // Vector width
  localparam int unsigned TABLE_DEPTH = 96;   // Vector table entries

  // ****************************************************************
  // Table layout
  // ****************************************************************
  localparam logic [CHAN_W-1:0] PHANTOM_ENTRY = 7'h00;
  localparam logic [CHAN_W-1:0] LAST_VEC_CHAN = 7'h5E;
  localparam logic              PARITY_ODD    = 1'b0;  // Even parity
  localparam logic [INDEX_W-1:0] INDEX_NONE   = 8'h00; // No pending

  // ****************************************************************
  // Default request line positions
  // ****************************************************************
  localparam int unsigned LN_ERR_HIGH   = 0;
  localparam int unsigned LN_TICK_CMP0  = 2;
  localparam int unsigned LN_TICK_CMP3  = 5;
  localparam int unsigned LN_TICK_OVF0  = 6;
  localparam int unsigned LN_TICK_OVF1  = 7;
  localparam int unsigned LN_HET_L0     = 10;
  localparam int unsigned LN_XFER_L0    = 11;
  localparam int unsigned LN_CONV_EVT   = 14;
  localparam int unsigned LN_CONV_SW1   = 15;
  localparam int unsigned LN_ERR_LOW    = 20;
  localparam int unsigned LN_SW_IRQ     = 21;
  localparam int unsigned LN_HET_L1     = 24;
  localparam int unsigned LN_XFER_L1    = 25;
  localparam int unsigned LN_CONV_SW2   = 28;
  localparam int unsigned LN_CONV_MAG   = 31;
  localparam int unsigned LN_CAN2_L0    = 35;
  localparam int unsigned LN_SER3_L0    = 37;
  localparam int unsigned LN_SER3_L1    = 38;
  localparam int unsigned LN_CAN2_L1    = 42;

  // Remaining live lines: io, serial, LIN, CAN one, core, flash, etc.
  localparam logic [CHAN_COUNT-1:0] OTHER_LIVE =
    96'h01350000_20000000_FFF3FEFD;

  // Live request lines; every reserved line is left out
  localparam logic [CHAN_COUNT-1:0] LIVE_MASK = OTHER_LIVE
    | (96'h1 << LN_ERR_HIGH) | (96'h1 << LN_TICK_CMP0)
    | (96'h1 << LN_TICK_CMP3) | (96'h1 << LN_TICK_OVF0)
    | (96'h1 << LN_TICK_OVF1) | (96'h1 << LN_HET_L0)
    | (96'h1 << LN_XFER_L0) | (96'h1 << LN_CONV_EVT)
    | (96'h1 << LN_CONV_SW1) | (96'h1 << LN_ERR_LOW)
    | (96'h1 << LN_SW_IRQ) | (96'h1 << LN_HET_L1)
    | (96'h1 << LN_XFER_L1) | (96'h1 << LN_CONV_SW2)
    | (96'h1 << LN_CONV_MAG) | (96'h1 << LN_CAN2_L0)
    | (96'h1 << LN_SER3_L0) | (96'h1 << LN_SER3_L1)
    | (96'h1 << LN_CAN2_L1);

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  // Vector table write
  typedef struct packed {
    logic              en;     // Write strobe
    logic [CHAN_W-1:0] entry;  // Table entry
    logic [VEC_W-1:0]  data;   // Vector value
  } vec_wr_t;

  // Request line to channel (priority) assignment write
  typedef struct packed {
    logic              en;     // Write strobe
    logic [CHAN_W-1:0] line;   // Request line
    logic [CHAN_W-1:0] chan;   // Channel it feeds
  } map_wr_t;

  // Dispatch result towards the core
  typedef struct packed {
    logic               valid;     // Request pending
    logic [INDEX_W-1:0] index;     // Channel plus one, zero if none
    logic [VEC_W-1:0]   vector;    // Service routine vector
    logic               parityErr; // Stored entry failed check
  } dispatch_t;

endpackage

// File: vectored_irq_manager.sv
// Vectored interrupt manager: mapping, priority, vector table, dispatch
`timescale 1ns/1ps
`default_nettype none
module vectored_irq_manager
(
  input  wire logic                               ref_clk,
  input  wire logic                               arst_n,
  input  wire logic [irq_mgr_pkg::CHAN_COUNT-1:0] irqLine,
  input  wire logic [irq_mgr_pkg::CHAN_COUNT-1:0] chanEnable,
  input  wire irq_mgr_pkg::map_wr_t               mapWr,
  input  wire irq_mgr_pkg::vec_wr_t               vecWr,
  output var  irq_mgr_pkg::dispatch_t             vicOut,
  output var  irq_mgr_pkg::dispatch_t             swOut
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Lowest numbered set bit wins; returns found flag and position
  function automatic logic [irq_mgr_pkg::CHAN_W:0] firstSet(
    input logic [irq_mgr_pkg::CHAN_COUNT-1:0] v);
    logic [irq_mgr_pkg::CHAN_W:0] r;
    r = '0;
    for (int i = irq_mgr_pkg::CHAN_COUNT - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = {1'b1, 7'(i)};
      end
    end
    return r;
  endfunction

  // Stored parity bit of a vector
  function automatic logic parityOf(
    input logic [irq_mgr_pkg::VEC_W-1:0] d);
    return (^d) ^ irq_mgr_pkg::PARITY_ODD;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  logic [irq_mgr_pkg::CHAN_W-1:0] mapReg  [irq_mgr_pkg::CHAN_COUNT];
  logic [irq_mgr_pkg::CHAN_W-1:0] mapNext [irq_mgr_pkg::CHAN_COUNT];
  logic [irq_mgr_pkg::VEC_W:0]    vecTable [irq_mgr_pkg::TABLE_DEPTH];
  logic                           winValid_reg;  // Stage one valid
  logic                           winValid_next;
  logic [irq_mgr_pkg::CHAN_W-1:0] winChan_reg;   // Stage one winner
  logic [irq_mgr_pkg::CHAN_W-1:0] winChan_next;
  irq_mgr_pkg::dispatch_t         out_reg;       // Stage two result
  irq_mgr_pkg::dispatch_t         out_next;
  logic [irq_mgr_pkg::CHAN_COUNT-1:0] liveReq;   // Masked lines
  logic [irq_mgr_pkg::CHAN_COUNT-1:0] chanPend;  // Per channel
  logic [irq_mgr_pkg::CHAN_W:0]       winner;    // Encoder result
  logic [irq_mgr_pkg::CHAN_W-1:0]     readEntry; // Table address
  logic [irq_mgr_pkg::VEC_W:0]        readWord;  // Data plus parity
  logic [irq_mgr_pkg::VEC_W:0]        phantWord; // Phantom entry

  // ****************************************************************
  // Channel assignment
  // ****************************************************************
  // Next mapping: software moves one request line per write
  always_comb
  begin
    for (int r = 0; r < irq_mgr_pkg::CHAN_COUNT; r++)
    begin
      mapNext[r] = mapReg[r];
    end
    if (mapWr.en && (mapWr.line < 7'(irq_mgr_pkg::CHAN_COUNT)))
    begin
      mapNext[mapWr.line] = mapWr.chan;
    end
  end

  // Reset gives identity: line n feeds channel n
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int r = 0; r < irq_mgr_pkg::CHAN_COUNT; r++)
      begin
        mapReg[r] <= 7'(r);
      end
    end
    else
    begin
      for (int r = 0; r < irq_mgr_pkg::CHAN_COUNT; r++)
      begin
        mapReg[r] <= mapNext[r];
      end
    end
  end

  // ****************************************************************
  // Pending and priority
  // ****************************************************************
  // Gather lines into channels; lower channel means higher priority
  always_comb
  begin
    liveReq  = irqLine & irq_mgr_pkg::LIVE_MASK;
    chanPend = '0;
    for (int r = 0; r < irq_mgr_pkg::CHAN_COUNT; r++)
    begin
      if (liveReq[r] && (mapReg[r] < 7'(irq_mgr_pkg::CHAN_COUNT)))
      begin
        chanPend[mapReg[r]] = 1'b1;
      end
    end
    chanPend      = chanPend & chanEnable;
    winner        = firstSet(chanPend);
    winValid_next = winner[irq_mgr_pkg::CHAN_W];
    winChan_next  = winner[irq_mgr_pkg::CHAN_W-1:0];
  end

  // Stage one registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      winValid_reg <= 1'b0;
      winChan_reg  <= '0;
    end
    else
    begin
      winValid_reg <= winValid_next;
      winChan_reg  <= winChan_next;
    end
  end

  // ****************************************************************
  // Vector table
  // ****************************************************************
  // Parity is generated on every write; no reset on the array
  always_ff @(posedge ref_clk)
  begin
    if (vecWr.en && (vecWr.entry < 7'(irq_mgr_pkg::TABLE_DEPTH)))
    begin
      vecTable[vecWr.entry] <= {parityOf(vecWr.data), vecWr.data};
    end
  end

  // ****************************************************************
  // Dispatch
  // ****************************************************************
  // Look up vector, check parity, build both dispatch views
  always_comb
  begin
    // Channel n sits one entry up; top channel has no entry
    if (winChan_reg > irq_mgr_pkg::LAST_VEC_CHAN)
    begin
      readEntry = irq_mgr_pkg::PHANTOM_ENTRY;
    end
    else
    begin
      readEntry = winChan_reg + 7'h01;
    end
    readWord  = vecTable[readEntry];
    phantWord = vecTable[irq_mgr_pkg::PHANTOM_ENTRY];
    out_next  = '0;
    if (winValid_reg)
    begin
      out_next.valid = 1'b1;
      out_next.index = {1'b0, winChan_reg} + 8'h01;
      // Bad entry falls back to the phantom routine
      if (parityOf(readWord[irq_mgr_pkg::VEC_W-1:0])
          != readWord[irq_mgr_pkg::VEC_W])
      begin
        out_next.parityErr = 1'b1;
        out_next.vector    = phantWord[irq_mgr_pkg::VEC_W-1:0];
      end
      else
      begin
        out_next.vector = readWord[irq_mgr_pkg::VEC_W-1:0];
      end
    end
    else
    begin
      out_next.index = irq_mgr_pkg::INDEX_NONE;
    end
  end

  // Stage two registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      out_reg <= '0;
    end
    else
    begin
      out_reg <= out_next;
    end
  end

  // Core port and software views come from the same flops
  assign vicOut = out_reg;
  assign swOut  = out_reg;

endmodule
`default_nettype wire

// File: vectored_irq_manager_asserts.sv
// Port assertions for the vectored interrupt manager
`timescale 1ns/1ps
`default_nettype none
module vectored_irq_manager_asserts
(
  input wire logic                   ref_clk,
  input wire logic                   arst_n,
  input wire logic [95:0]            irqLine,
  input wire logic [95:0]            chanEnable,
  input wire irq_mgr_pkg::map_wr_t   mapWr,
  input wire irq_mgr_pkg::vec_wr_t   vecWr,
  input wire irq_mgr_pkg::dispatch_t vicOut,
  input wire irq_mgr_pkg::dispatch_t swOut
);
  // ****
  // Dispatch checks
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_sw_mirror: assert property (swOut == vicOut)
    else $error("software view differs from core view");
  a_valid_index: assert property
    (vicOut.valid == (vicOut.index != 8'h00))
    else $error("index and valid disagree");
  a_index_range: assert property
    (vicOut.valid |-> vicOut.index <= 8'h60)
    else $error("index beyond channel count");
  a_off_quiet: assert property
    ((chanEnable == '0) [*5] |=> !vicOut.valid)
    else $error("request forwarded with all channels off");
  a_reserved_quiet: assert property
    (((irqLine & irq_mgr_pkg::LIVE_MASK) == '0) [*5] |=> !vicOut.valid)
    else $error("reserved line raised a request");
  a_reset_clear: assert property ($rose(arst_n) |-> vicOut == '0)
    else $error("outputs not clear after reset");
  // Output shows the lines sampled two edges earlier
  a_valid_cause: assert property
    (vicOut.valid |-> ($past(irqLine, 2) & irq_mgr_pkg::LIVE_MASK) != '0)
    else $error("request shown with no line raised");
  a_hold_steady: assert property
    (($stable(irqLine) && $stable(chanEnable) && !mapWr.en && !vecWr.en) [*4]
     |=> $stable(vicOut))
    else $error("dispatch changed with steady inputs");
  c_dispatch: cover property (vicOut.valid);
  c_last_chan: cover property (vicOut.index == 8'h5F);
  c_phantom: cover property (vicOut.index == 8'h60);
endmodule
`default_nettype wire

// File: core_port_model.sv
// Behavioural core vector port that takes dispatched vectors
`timescale 1ns/1ps
`default_nettype none
module core_port_model
(
  input wire logic                   ref_clk,
  input wire logic                   arst_n,
  input wire irq_mgr_pkg::dispatch_t vicOut,
  output var logic [31:0]            takenVec,
  output var int                     takenCnt
);
  // Core fetches the vector whenever a request is shown
  always @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      takenVec <= 32'h0;
      takenCnt <= 0;
    end
    else if (vicOut.valid)
    begin
      takenVec <= vicOut.vector;
      takenCnt <= takenCnt + 1;
    end
endmodule
`default_nettype wire

// File: vectored_irq_manager_tb.sv
// Self-checking bench for the vectored interrupt manager
`timescale 1ns/1ps
`default_nettype none
module vectored_irq_manager_tb;
  logic                   ref_clk    = 1'b0; // Clock
  logic                   arst_n     = 1'b0; // Reset
  logic [95:0]            irqLine    = '0;   // Request lines
  logic [95:0]            chanEnable = '0;   // Channel enables
  irq_mgr_pkg::map_wr_t   mapWr      = '0;   // Map write
  irq_mgr_pkg::vec_wr_t   vecWr      = '0;   // Table write
  irq_mgr_pkg::dispatch_t vicOut;            // Core view
  irq_mgr_pkg::dispatch_t swOut;             // Software view
  irq_mgr_pkg::dispatch_t expd;              // Model result
  logic [31:0]            tableM [96];       // Model vector table
  logic [31:0]            seed = 32'h13;     // Random state
  logic [31:0]            takenVec;          // Core fetch
  int                     takenCnt;          // Core fetch count
  int                     mapTo [96];        // Model line map
  int                     error_cnt = 0;
  int                     check_count = 0;
  int                     cycles = 0;
  logic [95:0] live = 96'h01350000_20000468_FFF3FEFD;

  always #2.5 ref_clk = ~ref_clk;

  vectored_irq_manager u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .irqLine(irqLine), .chanEnable(chanEnable), .mapWr(mapWr),
    .vecWr(vecWr), .vicOut(vicOut), .swOut(swOut));
  core_port_model u_core (.ref_clk(ref_clk), .arst_n(arst_n),
    .vicOut(vicOut), .takenVec(takenVec), .takenCnt(takenCnt));

  // ****
  // Helpers
  // ****
  task automatic chk(input logic [41:0] seen, input logic [41:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [95:0] rnd96();
    repeat (3)
    begin
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      rnd96 = {rnd96[63:0], seed};
    end
  endfunction
  // Drive lines and enables, then compare with the lowest-channel model
  task automatic apply(input logic [95:0] irq, input logic [95:0] en);
    int best;
    best = 96;
    @(posedge ref_clk);
    irqLine <= irq;
    chanEnable <= en;
    for (int l = 0; l < 96; l++)
      if (live[l] && irq[l] && en[mapTo[l]] && mapTo[l] < best)
        best = mapTo[l];
    expd = '0;
    if (best < 96)
    begin
      expd.valid = 1'b1;
      expd.index = 8'(best + 1);
      expd.vector = tableM[(best + 1) % 96];
    end
    repeat (4) @(posedge ref_clk);
    #1;
    chk(vicOut, expd);
    chk(swOut, expd);
    // Core model has fetched the shown vector
    if (expd.valid)
      chk(42'(takenVec), 42'(expd.vector));
  endtask
  task automatic remap(input int l, input int c);
    @(posedge ref_clk);
    mapWr <= '{1'b1, 7'(l), 7'(c)};
    mapTo[l] = c;
    @(posedge ref_clk);
    mapWr <= '0;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****
  // Main sequence
  // ****
  initial
  begin
    for (int i = 0; i < 96; i++)
      mapTo[i] = i;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (int e = 0; e < 96; e++)
    begin
      @(posedge ref_clk);
      tableM[e] = 32'(rnd96());
      vecWr <= '{1'b1, 7'(e), tableM[e]};
    end
    @(posedge ref_clk);
    vecWr <= '0;
    for (int l = 0; l < 96; l++)
      apply(96'h1 << l, '1);
    apply(96'h4, ~96'h4);
    remap(0, 94);
    remap(2, 94);
    apply(96'h5, '1);
    remap(20, 95);
    apply(96'h1 << 20, '1);
    repeat (150)
      apply(rnd96() & rnd96() & rnd96(), rnd96());
    // Mid-run reset clears a shown request and restores the identity map
    apply(96'h1 << 20, '1);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    #1;
    chk(vicOut, '0);
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 96; i++)
      mapTo[i] = i;
    apply(96'h1 << 20, '1);
    apply(96'h5, '1);
    chk(42'(takenCnt > 0), 42'h1);
    give_verdict();
  end

  // Cut a hang short
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
endmodule
bind vectored_irq_manager vectored_irq_manager_asserts u_chk (
  .ref_clk(ref_clk), .arst_n(arst_n), .irqLine(irqLine),
  .chanEnable(chanEnable), .mapWr(mapWr), .vecWr(vecWr),
  .vicOut(vicOut), .swOut(swOut));
`default_nettype wire
